// file: tcim_defines.vh
/*
 * constants for the capture-mode timer block: register offsets, field
 * positions, reset values, mode and edge codes, timing figures.
 * assumes: included by bare name from the design files of this block.
 */
`ifndef TCIM_DEFINES_VH
`define TCIM_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TCIM_OFF_CTRL0      12'h000
`define TCIM_OFF_CTRL1      12'h004
`define TCIM_OFF_CCRA0      12'h008
`define TCIM_OFF_CCRP0      12'h00c
`define TCIM_OFF_CNT0       12'h010
`define TCIM_OFF_CCRA1      12'h014
`define TCIM_OFF_CCRP1      12'h018
`define TCIM_OFF_CNT1       12'h01c
`define TCIM_OFF_STATUS     12'h020
`define TCIM_OFF_CLEAR      12'h024
`define TCIM_OFF_ENABLE     12'h028

// ---------------------------------------------------------------
// timer_control_reg_1 field positions (one per instance)
// ---------------------------------------------------------------
`define TCIM_CTL_RUN        0
`define TCIM_CTL_MODE_LO    4
`define TCIM_CTL_MODE_HI    5
`define TCIM_CTL_EDGE_LO    6
`define TCIM_CTL_EDGE_HI    7
`define TCIM_CTL_OC         8
`define TCIM_CTL_POL        9
`define TCIM_CTL_DPX        10
`define TCIM_CTL_CCLR       11
`define TCIM_CTL_CKEN       12
`define TCIM_CTL_W          13
`define TCIM_CTL_RST        13'h0000

// ---------------------------------------------------------------
// status bit layout: per instance, compare a flag then period flag
// ---------------------------------------------------------------
`define TCIM_ST_A0          0
`define TCIM_ST_P0          1
`define TCIM_ST_A1          2
`define TCIM_ST_P1          3
`define TCIM_ST_W           4

// ---------------------------------------------------------------
// codes and widths
// ---------------------------------------------------------------
`define TCIM_MODE_CAPTURE   2'h1
`define TCIM_EDGE_RISE      2'h0
`define TCIM_EDGE_FALL      2'h1
`define TCIM_EDGE_BOTH      2'h2
`define TCIM_EDGE_NONE      2'h3
`define TCIM_W0             10
`define TCIM_W1             16

// ---------------------------------------------------------------
// timing, in timer clock periods (a timer clock is one pclk here)
// ---------------------------------------------------------------
`define TCIM_MIN_PULSE_TCK  2
`define TCIM_FLAG_DLY_CYC   1

`endif

// file: tcim_sync.v
/*
 * two-flop synchroniser for one level coming from a pin.
 * assumes: the pin is asynchronous to pclk; only the second flop is read.
 */
module tcim_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire d,
  output reg  q
);

  reg meta_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // tcim_sync

// file: tcim_core.v
/*
 * one timer instance in capture input mode: counter, period compare,
 * edge detect and capture into compare register a.
 * assumes: pin already synchronised; clock enable from the top gates counting.
 */
`include "tcim_defines.vh"

module tcim_core #(
  parameter W = 10
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [12:0]  ctrl,
  input  wire [W-1:0] period,
  input  wire         pin_sync,
  output reg  [W-1:0] cnt_r,
  output reg  [W-1:0] cap_r,
  output reg          cap_evt_r,
  output reg          per_evt_r
);

  reg         pin_d_r;
  reg         run_d_r;
  wire        run      = ctrl[`TCIM_CTL_RUN];
  wire        ck_ok    = ctrl[`TCIM_CTL_CKEN];
  wire [1:0]  mode     = {ctrl[`TCIM_CTL_MODE_HI], ctrl[`TCIM_CTL_MODE_LO]};
  wire [1:0]  edge_sel = {ctrl[`TCIM_CTL_EDGE_HI], ctrl[`TCIM_CTL_EDGE_LO]};
  wire        capmode  = (mode == `TCIM_MODE_CAPTURE) && ck_ok;
  wire        rise     = pin_sync & ~pin_d_r;
  wire        fall     = ~pin_sync & pin_d_r;
  reg         hit;
  // zero period means the full range: match never fires, counter wraps
  wire        per_hit  = (period != {W{1'b0}}) && (cnt_r == period);

  // ---------------------------------------------------------------
  // edge selection
  // ---------------------------------------------------------------
  always @* begin
    case (edge_sel)
      `TCIM_EDGE_RISE: hit = rise;
      `TCIM_EDGE_FALL: hit = fall;
      `TCIM_EDGE_BOTH: hit = rise | fall;
      default:         hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // counter and capture; clear-source and dpx bits never read
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r   <= 1'b0;
      run_d_r   <= 1'b0;
      cnt_r     <= {W{1'b0}};
      cap_r     <= {W{1'b0}};
      cap_evt_r <= 1'b0;
      per_evt_r <= 1'b0;
    end else begin
      pin_d_r   <= pin_sync;
      run_d_r   <= run;
      cap_evt_r <= 1'b0;
      per_evt_r <= 1'b0;
      if (run && !run_d_r) begin
        cnt_r <= {W{1'b0}};
      end else if (run && capmode) begin
        if (per_hit) begin
          cnt_r     <= {W{1'b0}};
          per_evt_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
      end
      // capture one cycle after the synced edge, two to three pclk after the pin edge
      if (capmode && run && hit) begin
        cap_r     <= cnt_r;
        cap_evt_r <= 1'b1;
      end
    end
  end

endmodule // tcim_core

// file: tcim_top.v
/*
 * capture-mode timer pair with an apb register slave and one interrupt.
 * holds instance 0 (10-bit) and instance 1 (16-bit), flags, enable, irq.
 * assumes: apb master on pclk; capture pins asynchronous to pclk.
 */
// Decided for this implementation: register access over APB and the register offsets.
`include "tcim_defines.vh"

// Notes on behaviour
// - mode field value 01 selects capture input operation.
// - edge select picks rising, falling or both edges on the pin.
// - counter starts from zero when the run bit rises.
// - active edge copies counter into compare register a, raises interrupt.
// - counter free-runs regardless of pin until the run bit falls.
// - period match clears counter to zero and raises interrupt.
// - edge select 11 disables capture; counter keeps running.
// - clear source select and duty/period swap bits have no effect.
// - compare a flag sets half a timer clock after the latch; here it sets one pclk after the latch.
// - edge-to-latch latency stays under one and a half timer clocks; here it is two to three pclk from the pin.
// - no timer output is driven; output control and polarity ignored.
// - period value zero gives the full count range.
// - instance 0 has a 10-bit counter, instance 1 a 16-bit one.
// - no capture operation while the timer clock is absent.
module tcim_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        capture_input_pin_0,
  input  wire        capture_input_pin_1,
  output reg         irq
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [12:0]          ctrl0_r;
  reg  [12:0]          ctrl1_r;
  reg  [`TCIM_W0-1:0]  per0_r;
  reg  [`TCIM_W1-1:0]  per1_r;
  reg  [`TCIM_ST_W-1:0] stat_r;
  reg  [`TCIM_ST_W-1:0] ena_r;
  reg  [`TCIM_ST_W-1:0] clr;
  reg  [`TCIM_ST_W-1:0] stat_nxt;
  reg  [31:0]          rd_nxt;
  reg                  hit_nxt;
  wire                 pin0_s;
  wire                 pin1_s;
  wire [`TCIM_W0-1:0]  cnt0;
  wire [`TCIM_W0-1:0]  cap0;
  wire [`TCIM_W1-1:0]  cnt1;
  wire [`TCIM_W1-1:0]  cap1;
  wire                 ca0;
  wire                 cp0;
  wire                 ca1;
  wire                 cp1;
  // a write lands only at the edge where the master sees pready high,
  // so a clear cannot hit the flags twice in one access
  wire                 wr = psel & penable & pwrite & pready;
  wire [`TCIM_ST_W-1:0] evt = {cp1, ca1, cp0, ca0};

  // ---------------------------------------------------------------
  // pin synchronisers; pulses under two pclk may be lost
  // ---------------------------------------------------------------
  tcim_sync u_sync0 (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (capture_input_pin_0),
    .q       (pin0_s)
  );

  tcim_sync u_sync1 (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (capture_input_pin_1),
    .q       (pin1_s)
  );

  // ---------------------------------------------------------------
  // the two timer instances
  // ---------------------------------------------------------------
  tcim_core #(.W(`TCIM_W0)) u_tmr0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .ctrl      (ctrl0_r),
    .period    (per0_r),
    .pin_sync  (pin0_s),
    .cnt_r     (cnt0),
    .cap_r     (cap0),
    .cap_evt_r (ca0),
    .per_evt_r (cp0)
  );

  tcim_core #(.W(`TCIM_W1)) u_tmr1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .ctrl      (ctrl1_r),
    .period    (per1_r),
    .pin_sync  (pin1_s),
    .cnt_r     (cnt1),
    .cap_r     (cap1),
    .cap_evt_r (ca1),
    .per_evt_r (cp1)
  );

  // ---------------------------------------------------------------
  // write side; output control bits stored but drive nothing
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_r <= `TCIM_CTL_RST;
      ctrl1_r <= `TCIM_CTL_RST;
      per0_r  <= {`TCIM_W0{1'b0}};
      per1_r  <= {`TCIM_W1{1'b0}};
      ena_r   <= {`TCIM_ST_W{1'b0}};
    end else if (wr) begin
      case (paddr)
        `TCIM_OFF_CTRL0:  ctrl0_r <= pwdata[12:0];
        `TCIM_OFF_CTRL1:  ctrl1_r <= pwdata[12:0];
        `TCIM_OFF_CCRP0:  per0_r  <= pwdata[`TCIM_W0-1:0];
        `TCIM_OFF_CCRP1:  per1_r  <= pwdata[`TCIM_W1-1:0];
        `TCIM_OFF_ENABLE: ena_r   <= pwdata[`TCIM_ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sticky flags: a new event wins over a clear in the same cycle
  // ---------------------------------------------------------------
  always @* begin
    clr = {`TCIM_ST_W{1'b0}};
    if (wr && (paddr == `TCIM_OFF_CLEAR)) begin
      clr = pwdata[`TCIM_ST_W-1:0];
    end
    stat_nxt = (stat_r & ~clr) | evt;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= {`TCIM_ST_W{1'b0}};
      irq    <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq    <= |(stat_nxt & ena_r);
    end
  end

  // ---------------------------------------------------------------
  // read side and apb answer: one wait state, slverr on unmapped address
  // ---------------------------------------------------------------
  always @* begin
    rd_nxt  = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (paddr)
      `TCIM_OFF_CTRL0:  rd_nxt[12:0]           = ctrl0_r;
      `TCIM_OFF_CTRL1:  rd_nxt[12:0]           = ctrl1_r;
      `TCIM_OFF_CCRA0:  rd_nxt[`TCIM_W0-1:0]   = cap0;
      `TCIM_OFF_CCRP0:  rd_nxt[`TCIM_W0-1:0]   = per0_r;
      `TCIM_OFF_CNT0:   rd_nxt[`TCIM_W0-1:0]   = cnt0;
      `TCIM_OFF_CCRA1:  rd_nxt[`TCIM_W1-1:0]   = cap1;
      `TCIM_OFF_CCRP1:  rd_nxt[`TCIM_W1-1:0]   = per1_r;
      `TCIM_OFF_CNT1:   rd_nxt[`TCIM_W1-1:0]   = cnt1;
      `TCIM_OFF_STATUS: rd_nxt[`TCIM_ST_W-1:0] = stat_r;
      `TCIM_OFF_CLEAR:  rd_nxt                 = 32'h0000_0000;
      `TCIM_OFF_ENABLE: rd_nxt[`TCIM_ST_W-1:0] = ena_r;
      default:          hit_nxt                = 1'b0;
    endcase
  end

  // pready registered: one wait state, so every output is a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_nxt;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

endmodule // tcim_top

// file: tcim_monitor.sv
/* checker on the ports of the capture timer pair.
   assumes: bound to tcim_top; one clock domain, pclk. */
module tcim_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        capture_input_pin_0,
  input wire        capture_input_pin_1,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // shadows of control 0 and the enable mask
  // ----------------------------------------
  reg  [12:0] ctl0_r;
  reg  [3:0]  en_r;
  reg  [3:0]  quiet_r;
  wire        wr_done = psel && penable && pready && pwrite;
  // quiet_r: cycles since the last write, so the pin pipeline has settled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_r  <= 13'h0000;
      en_r    <= 4'h0;
      quiet_r <= 4'h0;
    end else begin
      if (wr_done && paddr == 12'h000)
        ctl0_r <= pwdata[12:0];
      if (wr_done && paddr == 12'h028)
        en_r <= pwdata[3:0];
      quiet_r <= wr_done ? 4'h0 : (quiet_r == 4'hf ? quiet_r : quiet_r + 4'h1);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_bad_read: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  chk_irq_masked: assert property (irq |-> en_r != 4'h0 || $past(en_r) != 4'h0)
    else $error("irq high with all sources masked");
  chk_cap_irq: assert property ($rose(capture_input_pin_0) && ctl0_r[12] && ctl0_r[0]
    && ctl0_r[5:4] == 2'h1 && !ctl0_r[6] && en_r[0] && quiet_r > 4'h2 |-> ##[1:5] irq)
    else $error("capture edge raised no interrupt in time");
  chk_no_cap_none: assert property (quiet_r > 4'h8 && en_r == 4'h1
    && ctl0_r[7:6] == 2'h3 |-> !$rose(irq))
    else $error("capture with edge select 11");
  chk_no_cap_clk: assert property (quiet_r > 4'h8 && en_r == 4'h1 && !ctl0_r[12]
    |-> !$rose(irq))
    else $error("capture with timer clock absent");
  cover property ($rose(irq));
  cover property (pslverr);
  cover property ($rose(capture_input_pin_1));
endmodule // tcim_monitor

// file: tcim_pulse_src.sv
/* pulse source on one capture pin: each request toggles the pin, except one made while hold_r is still counting down.
   assumes: requests come from the bench on pclk. */
module tcim_pulse_src (
  input  wire pclk,
  input  wire presetn,
  input  wire fire,
  output reg  pin
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] hold_r;
  // narrow pulses may be missed, so each level stands three clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin    <= 1'b0;
      hold_r <= 2'h0;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end else if (fire) begin
      pin    <= ~pin;
      hold_r <= 2'h2;
    end
  end
endmodule // tcim_pulse_src

// file: tb_tcim_top.sv
/* self-checking bench for the capture timer pair.
   assumes: tcim_top, tcim_pulse_src and tcim_monitor are compiled. */
`include "tcim_defines.vh"
module tb_tcim_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [1:0]  fire = 2'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [1:0]  pin;
  wire        irq;
  integer     err_total = 0;
  integer     comparisons = 0;
  reg  [31:0] q;
  reg  [31:0] q2;
  reg         e;
  always #2 pclk = ~pclk;
  tcim_top tcim_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .capture_input_pin_0(pin[0]),
    .capture_input_pin_1(pin[1]), .irq);
  tcim_pulse_src tcim_pulse_src_inst[1:0] (.pclk, .presetn, .fire(fire), .pin(pin));
  // ----------------------------------------
  // bus, pin and compare tasks
  // ----------------------------------------
  task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no local limit: only the watchdog ends a wait
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic tog(input integer k);
    begin
      fire[k] <= 1'b1;
      @(posedge pclk);
      fire[k] <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic chk_le(input [31:0] lo, input [31:0] got, input [31:0] hi);
    begin
      comparisons = comparisons + 1;
      if ((got >= lo && got <= hi) !== 1'b1) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    begin
      apb(0, `TCIM_OFF_CTRL0, 0);
      chk(q, 0);
      apb(0, `TCIM_OFF_STATUS, 0);
      chk(q, 0);
      apb(0, 12'h0fc, 0);
      chk({q[30:0], e}, 1);
      apb(1, `TCIM_OFF_CCRA0, 32'h55);
      apb(0, `TCIM_OFF_CCRA0, 0);
      chk(q, 0);
      apb(1, `TCIM_OFF_CCRP0, 32'hffffffff);
      apb(0, `TCIM_OFF_CCRP0, 0);
      chk(q, 32'h3ff);
      apb(1, `TCIM_OFF_CCRP1, 32'hffffffff);
      apb(0, `TCIM_OFF_CCRP1, 0);
      chk(q, 32'hffff);
      apb(1, `TCIM_OFF_CCRP0, 0);
    end
  endtask
  task t_edges;
    integer k;
    reg [31:0] lo;
    begin
      apb(1, `TCIM_OFF_ENABLE, 1);
      for (k = 0; k < 4; k = k + 1) begin
        apb(1, `TCIM_OFF_CTRL0, 32'h1011 | (k << 6) | (k[0] ? 32'hf00 : 0));
        apb(1, `TCIM_OFF_CLEAR, 32'hf);
        apb(0, `TCIM_OFF_CNT0, 0);
        lo = q;
        if (k == 0)
          chk_le(0, lo, 16);
        tog(0);
        apb(0, `TCIM_OFF_STATUS, 0);
        chk(q[0], k != 1 && k != 3);
        apb(0, `TCIM_OFF_CCRA0, 0);
        if (k == 0)
          chk_le(lo, q, lo + 16);
        apb(1, `TCIM_OFF_CLEAR, 32'hf);
        tog(0);
        apb(0, `TCIM_OFF_STATUS, 0);
        chk(q[0], k == 1 || k == 2);
        apb(0, `TCIM_OFF_CNT0, 0);
        if (k == 3)
          chk_le(lo + 1, q, lo + 200);
      end
    end
  endtask
  task t_gate;
    integer k;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        apb(1, `TCIM_OFF_CTRL0, k ? 32'h10a1 : 32'h0011);
        apb(1, `TCIM_OFF_CLEAR, 32'hf);
        tog(0);
        apb(0, `TCIM_OFF_STATUS, 0);
        chk(q[0], 0);
      end
    end
  endtask
  task t_wrap;
    begin
      apb(1, `TCIM_OFF_CTRL0, 32'h1010);
      apb(1, `TCIM_OFF_CTRL0, 32'h1011);
      repeat (1000) @(posedge pclk);
      apb(0, `TCIM_OFF_CNT0, 0);
      chk_le(1000, q, 1010);
      repeat (40) @(posedge pclk);
      apb(0, `TCIM_OFF_STATUS, 0);
      chk(q[1], 0);
      apb(0, `TCIM_OFF_CNT0, 0);
      chk_le(0, q, 80);
    end
  endtask
  task t_period;
    begin
      apb(1, `TCIM_OFF_CCRP1, 5);
      apb(1, `TCIM_OFF_ENABLE, 8);
      apb(1, `TCIM_OFF_CTRL1, 32'h1011);
      repeat (20) @(posedge pclk);
      chk(irq, 1);
      apb(0, `TCIM_OFF_CNT1, 0);
      chk_le(0, q, 5);
      tog(1);
      apb(0, `TCIM_OFF_STATUS, 0);
      chk(q[3:2], 3);
      apb(1, `TCIM_OFF_CTRL1, 32'h1010);
      apb(0, `TCIM_OFF_CNT1, 0);
      q2 = q;
      apb(0, `TCIM_OFF_CNT1, 0);
      chk(q, q2);
      apb(1, `TCIM_OFF_ENABLE, 0);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      apb(1, `TCIM_OFF_ENABLE, 8);
      repeat (2) @(posedge pclk);
      chk(irq, 1);
      apb(1, `TCIM_OFF_CLEAR, 8);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      apb(0, `TCIM_OFF_STATUS, 0);
      chk(q, 4);
      tog(1);
    end
  endtask
  // ----------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------
  task results;
    begin
      $display("counts: errors=%0d compares=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_edges;
    t_gate;
    t_wrap;
    t_period;
    results;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total = err_total + 1;
    results;
  end
endmodule // tb_tcim_top
bind tcim_top tcim_monitor tcim_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_input_pin_0,
  .capture_input_pin_1, .irq);
